/* rtl/mastat_pkg.sv */
// Package of register map, field layouts and struct carriers for the motor status bank
package mastat_pkg;

	// Printed offsets are not all multiples of four: they are register indices
	localparam logic [8:0] IDX_ALGORITHM_STATUS     = 9'h0E4;
	localparam logic [8:0] IDX_MEASURED_MOTOR_PARAMS = 9'h0E6;
	localparam logic [8:0] IDX_EXTRACTION_STATUS    = 9'h0E8;
	localparam logic [8:0] IDX_DEVICE_CONTROL_WORD  = 9'h0EA;
	localparam logic [8:0] IDX_IRQ_STATUS           = 9'h0F8;
	localparam logic [8:0] IDX_IRQ_MASK             = 9'h0F9;
	localparam logic [8:0] IDX_LOAD_CONTROL         = 9'h0FA;

	localparam int unsigned ADDR_W = 11;

	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

	// Field positions
	localparam int unsigned MOD_INDEX_LSB = 16;
	localparam int unsigned DUTY_LSB      = 4;
	localparam int unsigned READY_BIT     = 2;
	localparam int unsigned RES_LSB       = 24;
	localparam int unsigned BEMF_LSB      = 16;
	localparam int unsigned IND_LSB       = 8;
	localparam int unsigned STEP_R_BIT    = 31;
	localparam int unsigned STEP_L_BIT    = 30;
	localparam int unsigned STEP_KE_BIT   = 29;
	localparam int unsigned STEP_MECH_BIT = 28;
	localparam int unsigned FREQ_LSB      = 24;

	// Interrupt event bit positions
	localparam int unsigned EV_READY   = 0;
	localparam int unsigned EV_STEP    = 1;
	localparam int unsigned EV_PARAMS  = 2;
	localparam int unsigned EV_W       = 3;

	// Default copy-out time from shadow memory
	localparam int unsigned SHADOW_COPY_NS     = 1000;
	localparam int unsigned CLOCK_PERIOD_NS    = 4;
	localparam int unsigned SHADOW_COPY_CYCLES = (SHADOW_COPY_NS + CLOCK_PERIOD_NS - 1)
		/ CLOCK_PERIOD_NS;

	localparam logic [1:0] HTRANS_IDLE   = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic [15:0] applied_modulation_index;
		logic [11:0] speed_duty_command;
	} mastat_algo_t;

	typedef struct packed {
		logic [7:0] measured_resistance;
		logic [7:0] measured_back_emf_constant;
		logic [7:0] measured_inductance;
	} mastat_params_t;

	typedef struct packed {
		logic       resistance_step_status;
		logic       inductance_step_status;
		logic       back_emf_step_status;
		logic       mechanical_step_status;
		logic [3:0] suggested_switching_frequency;
	} mastat_extract_t;

endpackage

/* rtl/mastat_ready_seq.sv */
// Shadow memory copy sequencer that raises the host control ready flag
`timescale 1ns/1ns
module mastat_ready_seq #(
	parameter int unsigned COPY_CYCLES = mastat_pkg::SHADOW_COPY_CYCLES
) (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic copy_restart,
	output logic      copy_busy,
	output logic      host_control_ready
);

	typedef enum logic [2:0] {
		MASTAT_ST_RESET = 3'b001,
		MASTAT_ST_COPY  = 3'b010,
		MASTAT_ST_READY = 3'b100
	} mastat_seq_t;

	localparam int unsigned CNT_W = $clog2(COPY_CYCLES + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(COPY_CYCLES - 1);

	mastat_seq_t      state_q;
	mastat_seq_t      state_d;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;

	wire count_done = (count_q == LAST);

	always_comb
	begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
			MASTAT_ST_RESET:
			begin
				state_d = MASTAT_ST_COPY;
				count_d = '0;
			end
			MASTAT_ST_COPY:
			begin
				count_d = count_q + CNT_W'(1);
				if (count_done)
					state_d = MASTAT_ST_READY;
			end
			MASTAT_ST_READY:
			begin
				if (copy_restart)
					state_d = MASTAT_ST_RESET;
			end
			default:
				state_d = MASTAT_ST_RESET;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= MASTAT_ST_RESET;
			count_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			count_q <= count_d;
		end
	end

	// Flag stays low for the whole copy and only rises once it is complete
	assign copy_busy          = (state_q != MASTAT_ST_READY);
	assign host_control_ready = (state_q == MASTAT_ST_READY);

endmodule

/* rtl/mastat_regs.sv */
// Read-only motor algorithm status register bank with AHB-Lite slave and interrupt
`timescale 1ns/1ns
// Summary of operation
// - Status, parameter and extraction registers are read-only and zero after reset.
// - Bits 31..16 report applied modulation index, percent = value/32768*100.
// - Bits 15..4 report decoded speed duty, percent = value/4096*100.
// - Bit 2 stays 0 while defaults copy from shadow memory, then 1.
// - Resistance 31..24, back-EMF 23..16, inductance 15..8; bits 7..0 reserved.
// - Extraction step status bits: resistance 31, inductance 30, back-EMF 29, mechanical 28.
// - Bits 27..24 hold suggested switching frequency code; bits 23..0 reserved.
module mastat_regs #(
	parameter int unsigned COPY_CYCLES = mastat_pkg::SHADOW_COPY_CYCLES
) (
	input  wire logic                          clock,
	input  wire logic                          rst_b,
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic      [31:0]                   hrdata,
	output logic                               hreadyout,
	output logic                               hresp,
	input  wire mastat_pkg::mastat_algo_t      algo_in,
	input  wire logic                          algo_valid,
	input  wire mastat_pkg::mastat_params_t    params_in,
	input  wire logic                          params_valid,
	input  wire mastat_pkg::mastat_extract_t   extract_in,
	input  wire logic                          extract_valid,
	output logic                               host_control_ready,
	output logic                               irq
);

	//****************************************************************
	// Shadow copy sequencer
	//****************************************************************

	logic restart_q;
	logic copy_busy;
	logic ready_w;

	mastat_ready_seq #(
		.COPY_CYCLES (COPY_CYCLES)
	) u_seq (
		.clock              (clock),
		.rst_b              (rst_b),
		.copy_restart       (restart_q),
		.copy_busy          (copy_busy),
		.host_control_ready (ready_w)
	);

	//****************************************************************
	// Status holding registers
	//****************************************************************

	mastat_pkg::mastat_algo_t    algo_q;
	mastat_pkg::mastat_params_t  params_q;
	mastat_pkg::mastat_extract_t extract_q;
	logic                        ready_q;

	// Loads are frozen while defaults are still being copied: a strobe
	// that lands in the copy window is lost, the producer must repeat it
	wire load_ok      = !copy_busy;
	wire load_algo    = algo_valid && load_ok;
	wire load_params  = params_valid && load_ok;
	wire load_extract = extract_valid && load_ok;

	// Applied modulation index and decoded duty command
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			algo_q <= '0;
		else if (load_algo)
			algo_q <= algo_in;
	end

	// Measured winding values
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			params_q <= '0;
		else if (load_params)
			params_q <= params_in;
	end

	// Step flags and suggested switching frequency code
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			extract_q <= '0;
		else if (load_extract)
			extract_q <= extract_in;
	end

	// Own copy of the flag so bit 2 and the output pin change on one edge
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			ready_q <= 1'b0;
		else
			ready_q <= ready_w;
	end

	//****************************************************************
	// Read word assembly
	//****************************************************************

	function automatic logic [31:0] algo_word(
		input mastat_pkg::mastat_algo_t a,
		input logic                     rdy
	);
		logic [31:0] w;
		w = '0;
		w[mastat_pkg::MOD_INDEX_LSB +: 16] = a.applied_modulation_index;
		w[mastat_pkg::DUTY_LSB +: 12]      = a.speed_duty_command;
		w[mastat_pkg::READY_BIT]           = rdy;
		return w;
	endfunction

	function automatic logic [31:0] params_word(input mastat_pkg::mastat_params_t p);
		logic [31:0] w;
		w = '0;
		w[mastat_pkg::RES_LSB +: 8]  = p.measured_resistance;
		w[mastat_pkg::BEMF_LSB +: 8] = p.measured_back_emf_constant;
		w[mastat_pkg::IND_LSB +: 8]  = p.measured_inductance;
		return w;
	endfunction

	function automatic logic [31:0] extract_word(input mastat_pkg::mastat_extract_t e);
		logic [31:0] w;
		w = '0;
		w[mastat_pkg::STEP_R_BIT]    = e.resistance_step_status;
		w[mastat_pkg::STEP_L_BIT]    = e.inductance_step_status;
		w[mastat_pkg::STEP_KE_BIT]   = e.back_emf_step_status;
		w[mastat_pkg::STEP_MECH_BIT] = e.mechanical_step_status;
		w[mastat_pkg::FREQ_LSB +: 4] = e.suggested_switching_frequency;
		return w;
	endfunction

	function automatic logic [mastat_pkg::ADDR_W-1:0] byte_addr(input logic [8:0] idx);
		return {idx, 2'b00};
	endfunction

	//****************************************************************
	// Interrupt status and mask
	//****************************************************************

	localparam int unsigned EW = mastat_pkg::EV_W;

	logic [EW-1:0] irq_stat_q;
	logic [EW-1:0] irq_stat_d;
	logic [EW-1:0] irq_mask_q;
	logic [EW-1:0] irq_mask_d;
	logic [EW-1:0] irq_pend;
	logic [EW-1:0] events;
	logic [EW-1:0] clear_bits;

	wire ready_rise = ready_w && !ready_q;

	assign events[mastat_pkg::EV_READY]  = ready_rise;
	assign events[mastat_pkg::EV_STEP]   = load_extract;
	assign events[mastat_pkg::EV_PARAMS] = load_params;

	// A set arriving with its clear keeps the bit set, so no event is lost
	// to a clear that software aimed at an older one
	for (genvar g = 0; g < EW; g++)
	begin : g_irq_bit
		assign irq_stat_d[g] = (irq_stat_q[g] && !clear_bits[g]) || events[g];
		assign irq_pend[g]   = irq_stat_d[g] && irq_mask_d[g];
	end

	//****************************************************************
	// AHB-Lite slave
	//****************************************************************

	logic                       wr_pend_q;
	logic [mastat_pkg::ADDR_W-1:0] wr_addr_q;

	wire addr_phase = hsel && hready && (htrans == mastat_pkg::HTRANS_NONSEQ);
	wire [mastat_pkg::ADDR_W-1:0] a_addr = haddr[mastat_pkg::ADDR_W-1:0];

	wire hit_algo    = (a_addr == byte_addr(mastat_pkg::IDX_ALGORITHM_STATUS));
	wire hit_params  = (a_addr == byte_addr(mastat_pkg::IDX_MEASURED_MOTOR_PARAMS));
	wire hit_extract = (a_addr == byte_addr(mastat_pkg::IDX_EXTRACTION_STATUS));
	wire hit_istat   = (a_addr == byte_addr(mastat_pkg::IDX_IRQ_STATUS));
	wire hit_imask   = (a_addr == byte_addr(mastat_pkg::IDX_IRQ_MASK));

	//****************************************************************
	// Read data selection
	//****************************************************************

	function automatic logic [31:0] irq_word(input logic [EW-1:0] v);
		logic [31:0] w;
		w         = '0;
		w[EW-1:0] = v;
		return w;
	endfunction

	// Unlisted offsets, the control word included, read as zero
	logic [31:0] rd_mux;
	always_comb
	begin
		if (hit_algo)
			rd_mux = algo_word(algo_q, ready_q);
		else if (hit_params)
			rd_mux = params_word(params_q);
		else if (hit_extract)
			rd_mux = extract_word(extract_q);
		else if (hit_istat)
			rd_mux = irq_word(irq_stat_q);
		else if (hit_imask)
			rd_mux = irq_word(irq_mask_q);
		else
			rd_mux = '0;
	end

	//****************************************************************
	// Write data phase decode
	//****************************************************************

	wire wr_data_phase = wr_pend_q;
	wire wr_istat      = wr_data_phase
		&& (wr_addr_q == byte_addr(mastat_pkg::IDX_IRQ_STATUS));
	wire wr_imask      = wr_data_phase
		&& (wr_addr_q == byte_addr(mastat_pkg::IDX_IRQ_MASK));
	wire wr_load       = wr_data_phase
		&& (wr_addr_q == byte_addr(mastat_pkg::IDX_LOAD_CONTROL));

	assign clear_bits = wr_istat ? hwdata[EW-1:0] : '0;
	assign irq_mask_d = wr_imask ? hwdata[EW-1:0] : irq_mask_q;

	// Address phase split by direction
	wire wr_take = addr_phase && hwrite;
	wire rd_take = addr_phase && !hwrite;

	//****************************************************************
	// Bus phase registers
	//****************************************************************

	// Write data only arrives one cycle after its address, so the address
	// is parked here until the data phase
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			wr_pend_q <= 1'b0;
		else
			wr_pend_q <= wr_take;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			wr_addr_q <= '0;
		else if (addr_phase)
			wr_addr_q <= a_addr;
	end

	// Read data is captured at the address edge and holds until the next
	// read, so it is already stable through the whole data phase
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			hrdata <= mastat_pkg::STATUS_RESET;
		else if (rd_take)
			hrdata <= rd_mux;
	end

	//****************************************************************
	// Writable registers and interrupt output
	//****************************************************************

	// Status bank writes have no target: only mask, clear and reload are writable
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			irq_stat_q <= '0;
		else
			irq_stat_q <= irq_stat_d;
	end

	// Mask takes the written word in its data phase
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			irq_mask_q <= '0;
		else
			irq_mask_q <= irq_mask_d;
	end

	// Reload is a one-cycle pulse; the sequencer drops the ready flag on it
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			restart_q <= 1'b0;
		else
			restart_q <= wr_load && hwdata[0];
	end

	// Built from next-state values so the pin agrees with the registers
	// in the same cycle, at the cost of a longer path to the flip-flop
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= |irq_pend;
	end

	//****************************************************************
	// Bus response and ready pin
	//****************************************************************

	// Zero wait state slave, always OKAY; kept in flip-flops so every
	// output of the bank leaves a register
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Pin copy of the ready flag, one edge behind the sequencer
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			host_control_ready <= 1'b0;
		else
			host_control_ready <= ready_w;
	end

endmodule

/* bench/mastat_regs_monitor.sv */
// Concurrent checks on the status bank ports
`timescale 1ns/1ns
module mastat_regs_monitor #(
	parameter int unsigned COPY_CYCLES = mastat_pkg::SHADOW_COPY_CYCLES
) (
	input wire logic                       clock,
	input wire logic                       rst_b,
	input wire logic                       hsel,
	input wire logic [31:0]                haddr,
	input wire logic [1:0]                 htrans,
	input wire logic                       hwrite,
	input wire logic                       hready,
	input wire logic [31:0]                hrdata,
	input wire logic                       hreadyout,
	input wire logic                       hresp,
	input wire mastat_pkg::mastat_params_t params_in,
	input wire logic                       params_valid,
	input wire logic                       host_control_ready,
	input wire logic                       irq
);
	// *****
	// Decode and ready-low counter
	// *****
	wire       rd = hsel && hready && htrans == 2'h2 && !hwrite;
	wire [8:0] ix = haddr[10:2];
	wire       mapped = ix inside {9'h0E4, 9'h0E6, 9'h0E8, 9'h0F8, 9'h0F9, 9'h0FA};
	logic [15:0] low_q;
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			low_q <= 16'h0000;
		else
			low_q <= host_control_ready ? 16'h0000 : low_q + 16'h0001;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_bus_zero_wait: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or answered with error");
	a_ready_not_early: assert property ($rose(host_control_ready) |-> low_q >= COPY_CYCLES)
		else $error("ready flag rose before the copy finished");
	a_ready_in_time: assert property (low_q <= COPY_CYCLES + 3)
		else $error("ready flag stayed low too long");
	a_ready_bit_read: assert property (rd && ix == 9'h0E4
		|=> hrdata[2] == $past(host_control_ready))
		else $error("status bit 2 differs from ready flag");
	a_algo_reserved: assert property (rd && ix == 9'h0E4
		|=> hrdata[3] == 1'b0 && hrdata[1:0] == 2'h0)
		else $error("algorithm status reserved bits not zero");
	a_extract_reserved: assert property (rd && ix == 9'h0E8 |=> hrdata[23:0] == 24'h000000)
		else $error("extraction status reserved bits not zero");
	a_params_load: assert property (params_valid && host_control_ready
		##1 (rd && ix == 9'h0E6 && !params_valid)
		|=> hrdata == {$past(params_in, 2), 8'h00})
		else $error("measured parameters read back wrong");
	a_unmapped_zero: assert property (rd && !mapped |=> hrdata == 32'h00000000)
		else $error("unmapped read returned nonzero data");
	a_rdata_holds: assert property (!rd |=> $stable(hrdata))
		else $error("read data changed without a read");
	c_ready_rise: cover property ($rose(host_control_ready));
	c_irq_rise: cover property ($rose(irq));
	c_unmapped: cover property (rd && !mapped);
endmodule
bind mastat_regs mastat_regs_monitor #(.COPY_CYCLES(COPY_CYCLES)) i_mastat_regs_monitor (
	.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
	.params_in, .params_valid, .host_control_ready, .irq);

/* bench/mastat_host_model.sv */
// Bus host model issuing single word transfers
`timescale 1ns/1ns
module mastat_host_model (
	input  wire logic clock,
	input  wire logic hready,
	input  wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial
	begin
		hsel = 1'b1;
		haddr = 32'h00000000;
		htrans = mastat_pkg::HTRANS_IDLE;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
	end
	// Released lines flip so a stale value never passes for data
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		htrans <= mastat_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= mastat_pkg::HTRANS_IDLE;
		haddr <= ~a;
		hwdata <= w ? d : ~hwdata;
		do @(posedge clock); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d;
	endtask
endmodule

/* bench/tb_mastat_regs.sv */
// Self-checking bench for the motor status register bank
`timescale 1ns/1ns
module tb_mastat_regs;
	// *****
	// Signals
	// *****
	localparam int unsigned C = 4;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic hsel, hwrite, hrdy, hresp, rdy, irq, av, pv, xv;
	logic rd_ph = 1'b0;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	mastat_pkg::mastat_algo_t algo_in;
	mastat_pkg::mastat_params_t params_in;
	mastat_pkg::mastat_extract_t extract_in;
	logic [31:0] seed = 32'h9221;
	logic [31:0] exp_q[$];
	int n_mismatch = 0;
	int checked = 0;
	always #2 clock = ~clock;
	mastat_regs #(.COPY_CYCLES(C)) i_mastat_regs (.clock(clock), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .algo_in(algo_in),
		.algo_valid(av), .params_in(params_in), .params_valid(pv), .extract_in(extract_in),
		.extract_valid(xv), .host_control_ready(rdy), .irq(irq));
	mastat_host_model i_mastat_host_model (.clock(clock), .hready(hrdy), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	// *****
	// Tasks
	// *****
	function automatic logic [31:0] xr();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		exp_q.push_back(e);
		i_mastat_host_model.xfer(1'b0, a, 32'h0, q);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		i_mastat_host_model.xfer(1'b1, a, d, q);
	endtask
	task automatic ld(input logic [31:0] a, input logic [31:0] p, input logic [31:0] x,
		input logic [2:0] v);
		algo_in <= a[27:0];
		params_in <= p[23:0];
		extract_in <= x[7:0];
		{av, pv, xv} <= v;
		@(posedge clock);
		{av, pv, xv} <= 3'h0;
	endtask
	task automatic irq_is(input logic v);
		repeat (2) @(posedge clock);
		cmp("irq", {31'h0, v}, {31'h0, irq});
	endtask
	// Host may read the registers before the ready flag is up; only loads must wait for it
	task automatic wait_ready();
		int n;
		n = 0;
		while (rdy !== 1'b1 && n < 4 * C + 20)
		begin
			@(posedge clock);
			n++;
		end
		cmp("host_control_ready", 32'h1, {31'h0, rdy});
	endtask
	// Read data is judged at the edge that closes its data phase
	always @(posedge clock)
	begin
		if (rd_ph)
			cmp("hrdata", exp_q.pop_front(), hrdata);
		rd_ph <= hsel && htrans == mastat_pkg::HTRANS_NONSEQ && !hwrite && hrdy;
	end
	initial
	begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		close_out();
	end
	initial
	begin
		logic [31:0] a, p, x;
		logic [31:0] ev [3];
		logic [31:0] ad [3];
		algo_in = '0;
		params_in = '0;
		extract_in = '0;
		{av, pv, xv} = 3'h0;
		ad = '{32'h398, 32'h390, 32'h3A0};
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		rd(32'h390, 32'h0);
		rd(32'h398, 32'h0);
		rd(32'h3A0, 32'h0);
		rd(32'h3A8, 32'h0);
		wait_ready();
		for (int k = 0; k < 4; k++)
		begin
			a = (k == 0) ? 32'hFFFFFFFF : xr();
			p = (k == 0) ? 32'hFFFFFFFF : xr();
			x = (k == 0) ? 32'hFFFFFFFF : xr();
			ev = '{{p[23:0], 8'h00}, {a[27:0], 4'h4}, {x[7:0], 24'h000000}};
			ld(a, p, x, 3'h7);
			for (int j = 0; j < 3; j++)
				rd(ad[j], ev[j]);
			for (int j = 0; j < 3; j++)
			begin
				wr(ad[j], ~ev[j]);
				rd(ad[j], ev[j]);
			end
		end
		// Unlisted offset is only read, never written
		rd(32'h3FC, 32'h0);
		rd(32'h3E0, 32'h7);
		wr(32'h3E4, 32'h0);
		irq_is(1'b0);
		wr(32'h3E4, 32'h7);
		irq_is(1'b1);
		wr(32'h3E0, 32'h7);
		irq_is(1'b0);
		ld(a, p, x, 3'h1);
		irq_is(1'b1);
		rd(32'h3E0, 32'h2);
		wr(32'h3E4, 32'h5);
		irq_is(1'b0);
		wr(32'h3E8, 32'h1);
		repeat (2) @(posedge clock);
		ld(32'h0, p, x, 3'h4);
		rd(32'h390, {a[27:0], 4'h0});
		wait_ready();
		close_out();
	end
endmodule
